// *** logic/jpi_core.sv ***
// jpi_core: programming side of the test access port, with its own tap.
// assumes tck/tms/tdi are asynchronous pins, tck well below clk/4, and a
// memory controller on clk that answers page reads combinationally.
// Summary of operation
// [RULE1] four-bit instruction register decodes five codes into data paths, the rest to bypass
// [RULE2] run-test/idle produces the internal execute clock and serves as rest
// [RULE3] code c selects one-bit reset chain, never resets the tap itself
// [RULE4] a one in the chain holds core reset immediately, unlatched
// [RULE5] core stays reset a time-out period after the chain releases
// [RULE6] programmer resets the part through the chain before unlocking
// [RULE7] code 4 selects 16-bit unlock register, compared on update-dr
// [RULE8] programming allowed only while unlock register equals a370 hex
// [RULE9] power-on reset clears unlock register; programmer clears it leaving
// [RULE10] code 5 selects 15-bit command register, captures previous result
// [RULE11] shift result out as new command shifts in; update applies command
// [RULE12] entering idle after update gives exactly one execute pulse
// [RULE13] code 6 page fill chain: each shifted byte goes to page buffer
// [RULE14] code 7 page dump chain: page plus eight bits, tdi ignored
// [RULE15] page chains only when device is first in scan chain
// [RULE16] chip erase is three command words, polled on status bit
// [RULE17] flash write entry, address and data byte loads, latch sequence
// [RULE18] flash page write four words, polled until status done
// [RULE19] flash read entry; low byte second shift, high byte third
// [RULE20] eeprom write entry, data byte load, page write and poll
// [RULE21] eeprom read entry followed by address high and low loads
// [RULE22] programmer repeats poll until the status bit reads one
// [RULE23] every scan register shifts least significant bit first
// [RULE24] programmer may skip first latch word if control bits already set
// [RULE25] command splits into 7-bit control and 8-bit operand fields
// [RULE26] address bits beyond implemented memory are dropped on load
`timescale 1ns/1ps
`default_nettype none
module jpi_core #(
   parameter int ADDR_W = 14,
   parameter int PAGE_N = jpi_pkg::PAGE_BYTES,
   parameter int RESET_TIMEOUT_CYC = 65536
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   output logic core_reset,
   output logic prog_mode,
   output logic [jpi_pkg::CMD_W-1:0] mem_cmd,
   output logic mem_cmd_valid,
   output logic mem_exec,
   input wire logic [jpi_pkg::CMD_W-1:0] mem_result,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic page_wr_valid,
   output logic [jpi_pkg::BYTE_W-1:0] page_wr_data,
   output logic [$clog2(PAGE_N)-1:0] page_index,
   input wire logic [jpi_pkg::BYTE_W-1:0] page_rd_data
);
   import jpi_pkg::*;

   localparam int IDX_W = $clog2(PAGE_N);
   localparam logic [2:0] LAST_BIT = 3'h7;

   // command fields: control on top, operand below
   function automatic logic [CTRL_W-1:0] ctrl_of(input logic [CMD_W-1:0] c);
      ctrl_of = c[CMD_W-1:BYTE_W];
   endfunction

   // pin synchronisers, first stage read only by the second
   logic [2:0] tck_sync_q;
   logic [1:0] tms_sync_q;
   logic [1:0] tdi_sync_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tck_sync_q <= 3'h0;
         tms_sync_q <= 2'h0;
         tdi_sync_q <= 2'h0;
      end else begin
         tck_sync_q <= {tck_sync_q[1:0], tck};
         tms_sync_q <= {tms_sync_q[0], tms};
         tdi_sync_q <= {tdi_sync_q[0], tdi};
      end
   end

   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;
   assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
   assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
   assign tms_s = tms_sync_q[1];
   assign tdi_s = tdi_sync_q[1];

   // tap controller advanced on each sampled tck rise
   jpi_tap_t tap_q;
   jpi_tap_t tap_d;
   always_comb begin
      tap_d = tap_q;
      case (tap_q)
         JPI_TLR: tap_d = tms_s ? JPI_TLR : JPI_RTI;
         JPI_RTI: tap_d = tms_s ? JPI_SEL_DR : JPI_RTI;
         JPI_SEL_DR: tap_d = tms_s ? JPI_SEL_IR : JPI_CAP_DR;
         JPI_CAP_DR: tap_d = tms_s ? JPI_EX1_DR : JPI_SH_DR;
         JPI_SH_DR: tap_d = tms_s ? JPI_EX1_DR : JPI_SH_DR;
         JPI_EX1_DR: tap_d = tms_s ? JPI_UPD_DR : JPI_PA_DR;
         JPI_PA_DR: tap_d = tms_s ? JPI_EX2_DR : JPI_PA_DR;
         JPI_EX2_DR: tap_d = tms_s ? JPI_UPD_DR : JPI_SH_DR;
         JPI_UPD_DR: tap_d = tms_s ? JPI_SEL_DR : JPI_RTI;
         JPI_SEL_IR: tap_d = tms_s ? JPI_TLR : JPI_CAP_IR;
         JPI_CAP_IR: tap_d = tms_s ? JPI_EX1_IR : JPI_SH_IR;
         JPI_SH_IR: tap_d = tms_s ? JPI_EX1_IR : JPI_SH_IR;
         JPI_EX1_IR: tap_d = tms_s ? JPI_UPD_IR : JPI_PA_IR;
         JPI_PA_IR: tap_d = tms_s ? JPI_EX2_IR : JPI_PA_IR;
         JPI_EX2_IR: tap_d = tms_s ? JPI_UPD_IR : JPI_SH_IR;
         JPI_UPD_IR: tap_d = tms_s ? JPI_SEL_DR : JPI_RTI;
         default: tap_d = JPI_TLR;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tap_q <= JPI_TLR;
      end else if (tck_rise) begin
         tap_q <= tap_d;
      end
   end

   // per-edge strobes of the current state, acted on at this tck rise
   logic in_cap;
   logic in_shift;
   logic in_upd;
   assign in_cap = tck_rise && (tap_q == JPI_CAP_DR);
   assign in_shift = tck_rise && (tap_q == JPI_SH_DR);
   assign in_upd = tck_rise && (tap_q == JPI_UPD_DR);

   // [RULE1] instruction register
   // [RULE23] shifts lsb first
   logic [IR_W-1:0] ir_sh_q;
   logic [IR_W-1:0] ir_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ir_sh_q <= IR_CAPTURE;
         ir_q <= IR_BYPASS;
      end else if (tck_rise) begin
         if (tap_q == JPI_TLR)
            ir_q <= IR_BYPASS;
         else if (tap_q == JPI_CAP_IR)
            ir_sh_q <= IR_CAPTURE;
         else if (tap_q == JPI_SH_IR)
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
         else if (tap_q == JPI_UPD_IR)
            ir_q <= ir_sh_q;
      end
   end

   logic sel_rst;
   logic sel_unl;
   logic sel_cmd;
   logic sel_fill;
   logic sel_dump;
   assign sel_rst = (ir_q == core_reset_instruction);
   assign sel_unl = (ir_q == program_unlock_instruction);
   assign sel_cmd = (ir_q == program_command_instruction);
   assign sel_fill = (ir_q == page_fill_instruction);
   assign sel_dump = (ir_q == page_dump_instruction);

   // [RULE3] one-bit reset chain; tap state is untouched by it
   logic rst_chain_q;
   logic bypass_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rst_chain_q <= 1'b0;
         bypass_q <= 1'b0;
      end else if (in_shift) begin
         if (sel_rst)
            rst_chain_q <= tdi_s;
         bypass_q <= tdi_s;
      end
   end

   // [RULE5] time-out count after the chain lets go
   logic [$clog2(RESET_TIMEOUT_CYC+1)-1:0] tmo_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         tmo_q <= '0;
      else if (rst_chain_q)
         tmo_q <= ($clog2(RESET_TIMEOUT_CYC+1))'(RESET_TIMEOUT_CYC);
      else if (tmo_q != '0)
         tmo_q <= tmo_q - 1'b1;
   end

   // [RULE4] unlatched chain bit asserts core reset at once
   assign core_reset = rst_chain_q | (tmo_q != '0);

   // [RULE7] unlock register, compared on update
   // [RULE9] cleared by power-on reset
   logic [UNLOCK_W-1:0] unl_sh_q;
   logic [UNLOCK_W-1:0] unl_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         unl_sh_q <= UNLOCK_RST;
         unl_q <= UNLOCK_RST;
      end else if (sel_unl) begin
         if (in_shift)
            unl_sh_q <= {tdi_s, unl_sh_q[UNLOCK_W-1:1]};
         else if (in_upd)
            unl_q <= unl_sh_q;
      end
   end

   // [RULE8] programming only with exact signature held
   assign prog_mode = (unl_q == UNLOCK_SIG);

   // [RULE10] capture previous result
   // [RULE11] shift result out, command in, apply on update
   logic [CMD_W-1:0] cmd_sh_q;
   logic [CMD_W-1:0] cmd_q;
   logic cmd_valid_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmd_sh_q <= '0;
         cmd_q <= '0;
         cmd_valid_q <= 1'b0;
      end else begin
         cmd_valid_q <= 1'b0;
         if (sel_cmd && in_cap)
            cmd_sh_q <= mem_result;
         else if (sel_cmd && in_shift)
            cmd_sh_q <= {tdi_s, cmd_sh_q[CMD_W-1:1]};
         else if (sel_cmd && in_upd && prog_mode) begin
            cmd_q <= cmd_sh_q;
            cmd_valid_q <= 1'b1;
         end
      end
   end
   assign mem_cmd = cmd_q;
   assign mem_cmd_valid = cmd_valid_q;

   // [RULE2] idle clock source
   // [RULE12] one execute pulse per applied command
   logic exec_pend_q;
   logic exec_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         exec_pend_q <= 1'b0;
         exec_q <= 1'b0;
      end else begin
         exec_q <= 1'b0;
         if (cmd_valid_q)
            exec_pend_q <= 1'b1;
         else if (exec_pend_q && tck_rise && tap_q == JPI_RTI) begin
            exec_pend_q <= 1'b0;
            exec_q <= 1'b1;
         end
      end
   end
   assign mem_exec = exec_q;

   // [RULE25] control / operand split of applied command
   // [RULE26] address truncated to implemented width
   // [RULE17] [RULE21] address and data byte loads by prefix
   logic [ADDR_W-1:0] addr_q;
   logic [15:0] wdata_q;
   logic [CTRL_W-1:0] ctrl;
   logic [BYTE_W-1:0] opnd;
   assign ctrl = ctrl_of(cmd_sh_q);
   assign opnd = cmd_sh_q[BYTE_W-1:0];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addr_q <= '0;
         wdata_q <= '0;
      end else if (sel_cmd && in_upd && prog_mode) begin
         case (ctrl)
            CTRL_ADDR_HI: addr_q <= ADDR_W'({opnd, addr_q[BYTE_W-1:0]});
            CTRL_ADDR_LO:
               addr_q <= ADDR_W'({addr_q[ADDR_W-1:BYTE_W], opnd});
            CTRL_DATA_LO: wdata_q <= {wdata_q[15:8], opnd};
            CTRL_DATA_HI: wdata_q <= {opnd, wdata_q[7:0]};
            default: wdata_q <= wdata_q;
         endcase
      end
   end
   assign mem_addr = addr_q;
   assign mem_wdata = wdata_q;
   // [RULE16] [RULE18] [RULE19] [RULE20] erase, write, read and poll
   // words go out whole on mem_cmd; status returns via mem_result

   // [RULE13] page fill byte shifter
   // [RULE14] page dump byte shifter
   // [RULE15] chain length assumes this device is first
   logic [BYTE_W-1:0] pg_sh_q;
   logic [2:0] bit_q;
   logic [IDX_W-1:0] idx_q;
   logic wr_q;
   logic [BYTE_W-1:0] wr_data_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pg_sh_q <= '0;
         bit_q <= 3'h0;
         idx_q <= '0;
         wr_q <= 1'b0;
         wr_data_q <= '0;
      end else begin
         wr_q <= 1'b0;
         if ((sel_fill || sel_dump) && in_cap) begin
            // dump skips capture: shifter left as is, first byte is filler
            bit_q <= 3'h0;
            idx_q <= '0;
         end else if (sel_fill && in_shift) begin
            pg_sh_q <= {tdi_s, pg_sh_q[BYTE_W-1:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == LAST_BIT && prog_mode) begin
               wr_q <= 1'b1;
               wr_data_q <= {tdi_s, pg_sh_q[BYTE_W-1:1]};
               idx_q <= idx_q + 1'b1;
            end
         end else if (sel_dump && in_shift) begin
            bit_q <= bit_q + 3'h1;
            // tdi ignored; refill with fetched byte at byte end
            if (bit_q == LAST_BIT) begin
               pg_sh_q <= prog_mode ? page_rd_data : '0;
               idx_q <= idx_q + 1'b1;
            end else begin
               pg_sh_q <= {1'b0, pg_sh_q[BYTE_W-1:1]};
            end
         end
      end
   end
   // byte index runs ahead by one during fill, so report the written slot
   assign page_wr_valid = wr_q;
   assign page_wr_data = wr_data_q;
   assign page_index = sel_fill ? idx_q - 1'b1 : idx_q;

   // serial output source for the selected path
   logic tdo_src;
   always_comb begin
      tdo_src = bypass_q;
      if (tap_q == JPI_SH_IR)
         tdo_src = ir_sh_q[0];
      else if (sel_rst)
         tdo_src = rst_chain_q;
      else if (sel_unl)
         tdo_src = unl_sh_q[0];
      else if (sel_cmd)
         tdo_src = cmd_sh_q[0];
      else if (sel_fill || sel_dump)
         tdo_src = pg_sh_q[0];
   end

   // tdo changes on tck fall so the programmer samples it stable
   logic tdo_q;
   logic tdo_oe_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= tdo_src;
         tdo_oe_q <= (tap_q == JPI_SH_DR) || (tap_q == JPI_SH_IR);
      end
   end
   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;
endmodule // jpi_core
`default_nettype wire

// *** logic/jpi_pkg.sv ***
// jpi_pkg: constants shared by the test-port programming block.
// assumes a single 50 MHz system clock samples all test-port pins.
package jpi_pkg;
   // system clock
   localparam int CLK_HZ = 50000000;
   // instruction register and opcodes
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] core_reset_instruction = 4'hc;
   localparam logic [3:0] program_unlock_instruction = 4'h4;
   localparam logic [3:0] program_command_instruction = 4'h5;
   localparam logic [3:0] page_fill_instruction = 4'h6;
   localparam logic [3:0] page_dump_instruction = 4'h7;
   // data register widths
   localparam int UNLOCK_W = 16;
   localparam int CMD_W = 15;
   localparam int CTRL_W = 7;
   localparam int BYTE_W = 8;
   localparam logic [15:0] UNLOCK_SIG = 16'ha370;
   localparam logic [15:0] UNLOCK_RST = 16'h0000;
   // control field prefixes, upper seven command bits
   localparam logic [6:0] CTRL_ENTER = 7'h23;
   localparam logic [6:0] CTRL_ADDR_HI = 7'h07;
   localparam logic [6:0] CTRL_ADDR_LO = 7'h03;
   localparam logic [6:0] CTRL_DATA_LO = 7'h13;
   localparam logic [6:0] CTRL_DATA_HI = 7'h17;
   // status bit position in the returned command word
   localparam int STATUS_BIT = 9;
   // page geometry defaults (1024 bit page)
   localparam int PAGE_BYTES = 128;
   // tap controller states, gray steps along the data path
   typedef enum logic [3:0] {
      JPI_TLR = 4'h0, JPI_RTI = 4'h1, JPI_SEL_DR = 4'h3, JPI_CAP_DR = 4'h2,
      JPI_SH_DR = 4'h6, JPI_EX1_DR = 4'h7, JPI_PA_DR = 4'h5,
      JPI_EX2_DR = 4'h4, JPI_UPD_DR = 4'hc, JPI_SEL_IR = 4'hd,
      JPI_CAP_IR = 4'hf, JPI_SH_IR = 4'he, JPI_EX1_IR = 4'ha,
      JPI_PA_IR = 4'hb, JPI_EX2_IR = 4'h9, JPI_UPD_IR = 4'h8
   } jpi_tap_t;
endpackage

// *** verification/jpi_core_sva.sv ***
// jpi_core_sva: port-level checks on the programming block.
// assumes it is bound into every jpi_core instance.
`timescale 1ns/1ps
`default_nettype none
module jpi_core_sva
   import jpi_pkg::*;
#(
   parameter int RESET_TIMEOUT_CYC = 65536
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tdo_oe,
   input wire logic core_reset,
   input wire logic prog_mode,
   input wire logic [jpi_pkg::CMD_W-1:0] mem_cmd,
   input wire logic mem_cmd_valid,
   input wire logic mem_exec,
   input wire logic page_wr_valid
);
   int hi_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // cycles the core has been held so far
   always_ff @(posedge clk or posedge reset) begin
      if (reset) hi_q <= 0;
      else hi_q <= core_reset ? hi_q + 1 : 0;
   end
   sequence s_applied;
      mem_cmd_valid ##1 !mem_cmd_valid;
   endsequence
   sequence s_exec;
      ##[1:40] mem_exec ##1 !mem_exec;
   endsequence
   a_apply_pulse: assert property (
      mem_cmd_valid |=> !mem_cmd_valid) else $error("apply too long");
   a_cmd_held: assert property (
      $changed(mem_cmd) |-> mem_cmd_valid) else $error("command drifted");
   a_apply_update: assert property (
      mem_cmd_valid |-> !tdo_oe && prog_mode) else $error("bad apply");
   a_exec_once: assert property (
      s_applied |-> s_exec) else $error("no execute pulse");
   a_exec_pulse: assert property (
      mem_exec |=> !mem_exec [*4]) else $error("execute repeated");
   a_fill_shift: assert property (
      page_wr_valid |-> tdo_oe && prog_mode) else $error("bad fill");
   a_mode_update: assert property (
      $changed(prog_mode) |-> !tdo_oe) else $error("mode mid shift");
   a_reset_hold: assert property (
      $fell(core_reset) |-> $past(hi_q) >= RESET_TIMEOUT_CYC)
      else $error("core reset too short");
endmodule // jpi_core_sva
bind jpi_core jpi_core_sva #(.RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC)) u_sva (
   .clk(clk), .reset(reset), .tdo_oe(tdo_oe), .core_reset(core_reset),
   .prog_mode(prog_mode), .mem_cmd(mem_cmd), .mem_cmd_valid(mem_cmd_valid),
   .mem_exec(mem_exec), .page_wr_valid(page_wr_valid));
`default_nettype wire

// *** verification/jpi_prog.sv ***
// jpi_prog: behavioural programmer driving the test-port pins.
// assumes the device is the only part in the scan chain.
`timescale 1ns/1ps
`default_nettype none
module jpi_prog (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   logic o;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 160 ns period, tdo taken late so the sync delay has settled
   // pins move by nba on clk rise times, so callers start on a clk edge
   task automatic tick(input logic m, input logic d);
      tms <= m;
      tdi <= d;
      #80 tck <= 1'b1;
      #78 o = tdo;
      #2 tck <= 1'b0;
   endtask
   // tms steps lsb first; tdi flips as nothing shifts
   task automatic walk(input logic [7:0] p, input int n);
      for (int i = 0; i < n; i++) tick(p[i], ~tdi);
   endtask
   // sole device, lsb first
   // idle to idle plus one idle tick; tck stands low afterwards
   task automatic scan(input logic ir, input logic [63:0] d, input int n,
                       output logic [63:0] q);
      q = '0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, d[i]);
         q[i] = o;
      end
      walk(8'h01, 3);
   endtask
endmodule // jpi_prog
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: runs the programming block against a modelled programmer.
// assumes design, programmer model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import jpi_pkg::*;
   localparam int RST_TO = 200;
   localparam int PN = 4;
   localparam logic [15:0] SIG = 16'ha370;
   logic clk, reset, tck, tms, tdi, tdo, tdo_oe, core_reset, prog_mode;
   logic mem_cmd_valid, mem_exec, page_wr_valid;
   logic [14:0] mem_cmd, mem_result, r;
   logic [13:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [7:0] page_wr_data, page_rd_data;
   logic [1:0] page_index;
   logic [7:0] fill_q [PN];
   logic [63:0] so;
   int miscompares = 0;
   int checks = 0;
   int n_val = 0;
   int n_exe = 0;
   logic [14:0] cmds [31] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380,
      15'h2310, 15'h07ff, 15'h035a, 15'h1334, 15'h1712, 15'h3700, 15'h7700,
      15'h3700, 15'h3500, 15'h3700, 15'h3700, 15'h2302, 15'h3200, 15'h3600,
      15'h3700, 15'h2311, 15'h13c5, 15'h3700, 15'h7700, 15'h3700, 15'h3300,
      15'h3100, 15'h3300, 15'h3300, 15'h2303, 15'h07ab, 15'h0311};
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   jpi_core #(.ADDR_W(14), .PAGE_N(PN), .RESET_TIMEOUT_CYC(RST_TO))
   u_jpi_core (
      .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .core_reset(core_reset), .prog_mode(prog_mode),
      .mem_cmd(mem_cmd), .mem_cmd_valid(mem_cmd_valid), .mem_exec(mem_exec),
      .mem_result(mem_result), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .page_wr_valid(page_wr_valid), .page_wr_data(page_wr_data),
      .page_index(page_index), .page_rd_data(page_rd_data));
   jpi_prog u_jpi_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   // page buffer readout, combinational as the dump chain expects
   assign page_rd_data = 8'ha0 + {6'h00, page_index};
   // pulse counts and bytes the fill chain hands over
   always @(posedge clk) begin
      if (mem_cmd_valid === 1'b1) n_val++;
      if (mem_exec === 1'b1) n_exe++;
      if (page_wr_valid === 1'b1) fill_q[page_index] = page_wr_data;
   end
   task automatic chk(input string s, input logic [63:0] e,
                      input logic [63:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // data scan, then time for the pulses to land
   task automatic dr(input logic [63:0] d, input int n);
      u_jpi_prog.scan(1'b0, d, n, so);
      repeat (8) @(posedge clk);
   endtask
   task automatic ir(input logic [3:0] c);
      u_jpi_prog.scan(1'b1, {60'h0, c}, 4, so);
      chk("ir capture", 64'h1, so);
   endtask
   task automatic t_core_reset();
      int i;
      ir(core_reset_instruction);
      dr(64'h1, 1);
      chk("chain held", 1, core_reset);
      dr(64'h0, 1);
      for (i = 0; i < RST_TO && core_reset === 1'b1; i++) @(posedge clk);
      chk("held after release", 1, i > RST_TO - 60);
      chk("released", 0, core_reset);
      if (core_reset !== 1'b0) print_verdict();
   endtask
   task automatic t_unlock();
      ir(program_unlock_instruction);
      for (int b = 0; b < 16; b++) begin
         dr(64'(SIG ^ (16'h1 << b)), 16);
         chk("near signature", 0, prog_mode);
      end
      dr(64'(SIG), 16);
      chk("signature", 1, prog_mode);
   endtask
   task automatic t_commands();
      int v;
      int e;
      ir(program_command_instruction);
      foreach (cmds[k]) begin
         v = n_val;
         e = n_exe;
         r = 15'h0200 ^ 15'(k * 129);
         @(posedge clk) mem_result <= r;
         dr(64'(cmds[k]), 15);
         chk("result", 64'(r), so);
         chk("command", 64'(cmds[k]), 64'(mem_cmd));
         chk("apply", v + 1, n_val);
         chk("execute", e + 1, n_exe);
      end
      chk("address", 64'h2b11, 64'(mem_addr));
      chk("data", 64'h12c5, 64'(mem_wdata));
      v = n_val;
      so = '0;
      for (int p = 0; p < 8 && so[9] !== 1'b1; p++) begin
         @(posedge clk) mem_result <= 15'(p / 2 * 512);
         dr(64'h3700, 15);
      end
      chk("polls", v + 3, n_val);
      // a poll that never reports done ends the run here
      if (so[9] !== 1'b1) print_verdict();
   endtask
   task automatic t_pages();
      r = mem_cmd;
      ir(page_fill_instruction);
      dr(64'h44332211, 8 * PN);
      for (int b = 0; b < PN; b++)
         chk("fill", 64'(17 * (b + 1)), 64'(fill_q[b]));
      chk("no update", 64'(r), 64'(mem_cmd));
      ir(page_dump_instruction);
      dr({64{1'b1}}, 8 + 8 * PN);
      chk("dump", 64'ha3a2a1a0, so >> 8);
   endtask
   task automatic t_lock();
      int v;
      ir(program_unlock_instruction);
      dr(64'h0, 16);
      chk("locked", 0, prog_mode);
      v = n_val;
      ir(program_command_instruction);
      dr(64'h2380, 15);
      chk("refused", v, n_val);
   endtask
   initial begin
      reset = 1'b1;
      mem_result = '0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      chk("oe", 0, tdo_oe);
      chk("mode", 0, prog_mode);
      chk("cmd", 0, 64'(mem_cmd));
      u_jpi_prog.walk(8'h1f, 6);
      t_core_reset();
      t_unlock();
      t_commands();
      t_pages();
      t_lock();
      print_verdict();
   end
   // hang guard
   initial begin
      #1500000;
      miscompares++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
